// *** rtl/sgc_params.svh ***
// Register map, field positions, reset values and timing counts of the global control bits
// Behaviour
// - Filter select picks pause-type or flow-control discards
// - Link loss triggers one fast age cycle
// - Any unplugged port flushes every learned address
// - Pass-all forwards every frame, errored included
// - Bit 5 disables transmit pause over negotiation
// - Bit 4 disables receive pause over negotiation
// - One strap presets both pause disables
// - Length check drops mismatched short frames
// - Bit 2 enables aging, strap preset
// - Fast-age bit selects the 800 us period
// - Aggressive backoff bit, strap preset, default off
// - Port-VLAN discard bit governs unicast crossing
`ifndef SGC_PARAMS_SVH
`define SGC_PARAMS_SVH

`define SGC_OFS_CTRL0          8'h02
`define SGC_OFS_CTRL1          8'h03
`define SGC_OFS_CTRL2          8'h04

`define SGC_C0_FILTER_SEL_BIT  1
`define SGC_C0_LINK_AGE_BIT    0
`define SGC_C1_PASS_ALL_BIT    7
`define SGC_C1_RSVD_BIT        6
`define SGC_C1_TX_PAUSE_DIS    5
`define SGC_C1_RX_PAUSE_DIS    4
`define SGC_C1_LEN_CHECK_BIT   3
`define SGC_C1_AGING_EN_BIT    2
`define SGC_C1_FAST_AGE_BIT    1
`define SGC_C1_BACKOFF_BIT     0
`define SGC_C2_VLAN_DISC_BIT   7

`define SGC_RST_CTRL0          8'h00
`define SGC_RST_CTRL1          8'h04
`define SGC_RST_CTRL2          8'h80

`define SGC_PAUSE_TYPE         16'h8808
`define SGC_PAUSE_DEST         48'h0180c2000001
`define SGC_MAX_LEN_FIELD      16'd1500

`define SGC_CLK_HZ             40000000
`define SGC_NORMAL_AGE_S       300
`define SGC_AGE_SLACK_S        75
`define SGC_FAST_AGE_US        800
`define SGC_FAST_AGE_CYC       (`SGC_FAST_AGE_US * (`SGC_CLK_HZ / 1000000))
`define SGC_NORMAL_AGE_CYC     (64'd300 * 64'd40000000)
`define SGC_STRAP_LOAD_CYC     2'd2

`endif

// *** rtl/sgc_pkg.sv ***
// Types shared by the global control bits
package sgc_pkg;
  typedef logic [33:0] sgc_age_cnt_t;
  typedef enum logic [2:0] {
    SGC_ST_IDLE  = 3'b001,
    SGC_ST_FAST  = 3'b010,
    SGC_ST_NORM  = 3'b100
  } sgc_age_state_t;
endpackage

// *** rtl/sgc_age_if.sv ***
// Carrier between the control bank and its aging timer
`timescale 1ns/1ps
interface sgc_age_if;
  logic aging_en;
  logic fast_mode;
  logic fast_req;
  logic age_tick;
  modport ctrl (output aging_en, output fast_mode, output fast_req, input age_tick);
  modport timer (input aging_en, input fast_mode, input fast_req, output age_tick);
endinterface

// *** rtl/sgc_age_timer.sv ***
// Address aging period timer with normal, fast and one-shot fast periods
`timescale 1ns/1ps
`include "sgc_params.svh"
module sgc_age_timer
  import sgc_pkg::*;
#(
  parameter sgc_age_cnt_t NORMAL_CYC = sgc_age_cnt_t'(`SGC_NORMAL_AGE_CYC),
  parameter sgc_age_cnt_t FAST_CYC   = sgc_age_cnt_t'(`SGC_FAST_AGE_CYC)
) (
  input  wire logic   clk_in,
  input  wire logic   rst_n_in,
  input  wire logic   ce_in,
  sgc_age_if.timer    age
);
  sgc_age_state_t state;
  sgc_age_cnt_t   cnt;
  logic           period_end;
  logic           fast_pending;

  assign period_end = (state == SGC_ST_FAST) ? (cnt >= FAST_CYC - 34'd1)
                                             : (cnt >= NORMAL_CYC - 34'd1);

  // Request is held until its fast cycle ends; a new one the same cycle wins
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      fast_pending <= 1'b0;
    end else if (ce_in) begin
      if (age.fast_req) begin
        fast_pending <= 1'b1;
      end else if (state == SGC_ST_FAST && period_end) begin
        fast_pending <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state    <= SGC_ST_IDLE;
      cnt      <= '0;
      age.age_tick <= 1'b0;
    end else if (ce_in) begin
      age.age_tick <= 1'b0;
      unique case (state)
        SGC_ST_IDLE: begin
          cnt <= '0;
          if (age.aging_en) begin
            state <= (age.fast_mode || fast_pending) ? SGC_ST_FAST : SGC_ST_NORM;
          end
        end
        SGC_ST_FAST, SGC_ST_NORM: begin
          if (!age.aging_en) begin
            state <= SGC_ST_IDLE;
          end else if (period_end) begin
            cnt          <= '0;
            age.age_tick <= 1'b1;
            // Back to the normal period once the one-shot cycle is done
            state <= (age.fast_mode || age.fast_req) ? SGC_ST_FAST : SGC_ST_NORM;
          end else begin
            cnt <= cnt + 34'd1;
            // Switch to fast at once rather than wait out a 300 s period
            if (state == SGC_ST_NORM && (age.fast_mode || age.fast_req)) begin
              state <= SGC_ST_FAST;
              cnt   <= '0;
            end
          end
        end
        default: state <= SGC_ST_IDLE;
      endcase
    end
  end
endmodule // sgc_age_timer

// *** rtl/sgc_top.sv ***
// Global control bits of the switch: registers, frame filters, pause gates and aging
`timescale 1ns/1ps
`include "sgc_params.svh"
module sgc_top
  import sgc_pkg::*;
#(
  parameter sgc_age_cnt_t NORMAL_AGE_CYC = sgc_age_cnt_t'(`SGC_NORMAL_AGE_CYC),
  parameter sgc_age_cnt_t FAST_AGE_CYC   = sgc_age_cnt_t'(`SGC_FAST_AGE_CYC)
) (
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        ce_in,
  input  wire logic [7:0]  reg_addr_in,
  input  wire logic        reg_wr_in,
  input  wire logic [7:0]  reg_wdata_in,
  input  wire logic        reg_rd_in,
  output logic      [7:0]  reg_rdata_out,
  input  wire logic        pause_strap_pin_in,
  input  wire logic        backoff_strap_pin_in,
  input  wire logic        aging_strap_pin_in,
  input  wire logic [4:0]  link_up_in,
  input  wire logic        an_tx_pause_in,
  input  wire logic        an_rx_pause_in,
  input  wire logic        frame_valid_in,
  input  wire logic [15:0] frame_type_len_in,
  input  wire logic [47:0] frame_dest_in,
  input  wire logic        frame_flow_ctl_in,
  input  wire logic        frame_err_in,
  input  wire logic [15:0] frame_len_in,
  input  wire logic        frame_vlan_cross_in,
  input  wire logic        frame_known_ucast_in,
  output logic             frame_done_out,
  output logic             frame_keep_out,
  output logic             tx_pause_en_out,
  output logic             rx_pause_en_out,
  output logic             backoff_aggr_out,
  output logic             pass_all_out,
  output logic             age_tick_out,
  output logic             flush_all_out
);
  logic [7:0] ctrl0;
  logic [7:0] ctrl1;
  logic [7:0] ctrl2;
  logic [2:0] strap_s1;
  logic [2:0] strap_s2;
  logic [1:0] strap_cnt;
  logic       strap_load;
  logic [4:0] link_q;
  logic [4:0] link_lost;
  logic       next_keep;

  sgc_age_if age_bus ();

  // Address decode shared by write and read paths
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
    hit = (addr == ofs);
  endfunction

  // Straps are asynchronous pins, so two flops before anything reads them
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      strap_s1 <= 3'h0;
      strap_s2 <= 3'h0;
    end else if (ce_in) begin
      strap_s1 <= {pause_strap_pin_in, backoff_strap_pin_in, aging_strap_pin_in};
      strap_s2 <= strap_s1;
    end
  end

  // Straps land once the synchroniser has filled after reset release
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      strap_cnt <= 2'h0;
    end else if (ce_in && strap_cnt != 2'h3) begin
      strap_cnt <= strap_cnt + 2'h1;
    end
  end
  assign strap_load = (strap_cnt == `SGC_STRAP_LOAD_CYC);

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctrl0 <= `SGC_RST_CTRL0;
    end else if (ce_in && reg_wr_in && hit(reg_addr_in, `SGC_OFS_CTRL0)) begin
      ctrl0[`SGC_C0_FILTER_SEL_BIT] <= reg_wdata_in[`SGC_C0_FILTER_SEL_BIT];
      ctrl0[`SGC_C0_LINK_AGE_BIT]   <= reg_wdata_in[`SGC_C0_LINK_AGE_BIT];
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctrl1 <= `SGC_RST_CTRL1;
    end else if (ce_in) begin
      if (strap_load) begin
        ctrl1[`SGC_C1_TX_PAUSE_DIS] <= strap_s2[2];
        ctrl1[`SGC_C1_RX_PAUSE_DIS] <= strap_s2[2];
        ctrl1[`SGC_C1_BACKOFF_BIT]  <= strap_s2[1];
        ctrl1[`SGC_C1_AGING_EN_BIT] <= strap_s2[0];
      end else if (reg_wr_in && hit(reg_addr_in, `SGC_OFS_CTRL1)) begin
        // Whole byte, so both pause bits are independent and bit 6 just stores
        ctrl1 <= reg_wdata_in;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctrl2 <= `SGC_RST_CTRL2;
    end else if (ce_in && reg_wr_in && hit(reg_addr_in, `SGC_OFS_CTRL2)) begin
      ctrl2[`SGC_C2_VLAN_DISC_BIT] <= reg_wdata_in[`SGC_C2_VLAN_DISC_BIT];
    end
  end

  // Unmapped addresses read zero
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      reg_rdata_out <= 8'h00;
    end else if (ce_in && reg_rd_in) begin
      if (hit(reg_addr_in, `SGC_OFS_CTRL0)) begin
        reg_rdata_out <= ctrl0;
      end else if (hit(reg_addr_in, `SGC_OFS_CTRL1)) begin
        reg_rdata_out <= ctrl1;
      end else if (hit(reg_addr_in, `SGC_OFS_CTRL2)) begin
        reg_rdata_out <= ctrl2;
      end else begin
        reg_rdata_out <= 8'h00;
      end
    end
  end

  // Pause gating on the negotiated result
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tx_pause_en_out  <= 1'b0;
      rx_pause_en_out  <= 1'b0;
      backoff_aggr_out <= 1'b0;
      pass_all_out     <= 1'b0;
    end else if (ce_in) begin
      tx_pause_en_out  <= an_tx_pause_in & ~ctrl1[`SGC_C1_TX_PAUSE_DIS];
      rx_pause_en_out  <= an_rx_pause_in & ~ctrl1[`SGC_C1_RX_PAUSE_DIS];
      backoff_aggr_out <= ctrl1[`SGC_C1_BACKOFF_BIT];
      pass_all_out     <= ctrl1[`SGC_C1_PASS_ALL_BIT];
    end
  end

  // Frame verdict; pass-all overrides every discard for debug capture
  always_comb begin
    next_keep = 1'b1;
    if (ctrl0[`SGC_C0_FILTER_SEL_BIT]) begin
      if (frame_type_len_in == `SGC_PAUSE_TYPE || frame_dest_in == `SGC_PAUSE_DEST) begin
        next_keep = 1'b0;
      end
    end else if (frame_flow_ctl_in) begin
      next_keep = 1'b0;
    end
    if (ctrl1[`SGC_C1_LEN_CHECK_BIT] && frame_type_len_in < `SGC_MAX_LEN_FIELD
        && frame_type_len_in != frame_len_in) begin
      next_keep = 1'b0;
    end
    if (frame_err_in) begin
      next_keep = 1'b0;
    end
    if (frame_vlan_cross_in) begin
      if (ctrl2[`SGC_C2_VLAN_DISC_BIT] || !frame_known_ucast_in) begin
        next_keep = 1'b0;
      end
    end
    if (ctrl1[`SGC_C1_PASS_ALL_BIT]) begin
      next_keep = 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      frame_done_out <= 1'b0;
      frame_keep_out <= 1'b0;
    end else if (ce_in) begin
      frame_done_out <= frame_valid_in;
      if (frame_valid_in) begin
        frame_keep_out <= next_keep;
      end
    end
  end

  // Link loss edge detect; link status shares this clock
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      link_q <= 5'h00;
    end else if (ce_in) begin
      link_q <= link_up_in;
    end
  end
  assign link_lost = link_q & ~link_up_in;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      flush_all_out <= 1'b0;
    end else if (ce_in) begin
      flush_all_out <= |link_lost;
    end
  end

  assign age_bus.aging_en  = ctrl1[`SGC_C1_AGING_EN_BIT];
  assign age_bus.fast_mode = ctrl1[`SGC_C1_FAST_AGE_BIT];
  assign age_bus.fast_req  = ctrl0[`SGC_C0_LINK_AGE_BIT] & (|link_lost);

  sgc_age_timer #(
    .NORMAL_CYC (NORMAL_AGE_CYC),
    .FAST_CYC   (FAST_AGE_CYC)
  ) u_age_timer (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .ce_in    (ce_in),
    .age      (age_bus.timer)
  );

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      age_tick_out <= 1'b0;
    end else if (ce_in) begin
      age_tick_out <= age_bus.age_tick;
    end
  end
endmodule // sgc_top

// *** test/sgc_checker.sv ***
// Concurrent checks on the global control ports
`timescale 1ns/1ps
module sgc_checker (
  input wire logic       clk_in,
  input wire logic       rst_n_in,
  input wire logic       ce_in,
  input wire logic       reg_wr_in,
  input wire logic       reg_rd_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic [4:0] link_up_in,
  input wire logic       an_tx_pause_in,
  input wire logic       an_rx_pause_in,
  input wire logic       frame_valid_in,
  input wire logic       frame_err_in,
  input wire logic       frame_done_out,
  input wire logic       frame_keep_out,
  input wire logic       tx_pause_en_out,
  input wire logic       rx_pause_en_out,
  input wire logic       pass_all_out,
  input wire logic       flush_all_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_frame;
    ce_in && frame_valid_in;
  endsequence
  // Pass-all output lags its bit, so skip frames right after a write
  sequence s_settled;
    !$past(reg_wr_in);
  endsequence
  chk_done_follows: assert property (s_frame |=> frame_done_out)
    else $error("verdict missing after frame");
  chk_done_cause: assert property (frame_done_out |-> $past(frame_valid_in && ce_in))
    else $error("verdict without frame");
  chk_pass_keep: assert property (s_frame ##0 s_settled ##0 pass_all_out |=> frame_keep_out)
    else $error("pass-all frame dropped");
  chk_err_drop: assert property (s_frame ##0 s_settled ##0 (frame_err_in && !pass_all_out)
    |=> !frame_keep_out)
    else $error("errored frame kept");
  chk_tx_gate: assert property ($past(ce_in) && tx_pause_en_out |-> $past(an_tx_pause_in))
    else $error("tx pause without negotiation");
  chk_rx_gate: assert property ($past(ce_in) && rx_pause_en_out |-> $past(an_rx_pause_in))
    else $error("rx pause without negotiation");
  chk_flush_unplug: assert property (ce_in && $past(ce_in) && |($past(link_up_in) & ~link_up_in)
    |=> flush_all_out)
    else $error("no flush on unplug");
  chk_flush_cause: assert property (flush_all_out |-> |($past(link_up_in, 2) & ~$past(link_up_in)))
    else $error("flush without unplug");
  chk_rdata_hold: assert property ($changed(reg_rdata_out) |-> $past(reg_rd_in && ce_in))
    else $error("read data moved without read");
endmodule // sgc_checker

bind sgc_top sgc_checker u_chk (.*);

// *** test/sgc_top_bench.sv ***
// Self-checking bench for the global control bits
`timescale 1ns/1ps
`include "sgc_params.svh"
module sgc_top_bench;
  logic        clk_in = 1'b0, rst_n_in = 1'b0, ce_in = 1'b1;
  logic        reg_wr_in = 1'b0, reg_rd_in = 1'b0, frame_valid_in = 1'b0;
  logic        pause_strap_pin_in = 1'b1, backoff_strap_pin_in = 1'b1, aging_strap_pin_in = 1'b0;
  logic        an_tx_pause_in = 1'b1, an_rx_pause_in = 1'b1, frame_flow_ctl_in = 1'b0;
  logic        frame_err_in = 1'b0, frame_vlan_cross_in = 1'b0, frame_known_ucast_in = 1'b0;
  logic [7:0]  reg_addr_in = 8'h00, reg_wdata_in = 8'h00, reg_rdata_out;
  logic [4:0]  link_up_in = 5'h1f;
  logic [15:0] frame_type_len_in = 16'h0800, frame_len_in = 16'h0000;
  logic [47:0] frame_dest_in = 48'h0;
  logic        frame_done_out, frame_keep_out, tx_pause_en_out, rx_pause_en_out;
  logic        backoff_aggr_out, pass_all_out, age_tick_out, flush_all_out;
  int          n_fail = 0, n_checks = 0, cyc = 0;
  // Short aging counts keep the run brief
  sgc_top #(.NORMAL_AGE_CYC(34'd200), .FAST_AGE_CYC(34'd20)) uut (.*);
  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge clk_in) #2;
    reg_addr_in = a;
    reg_wdata_in = d;
    reg_wr_in = 1'b1;
    @(posedge clk_in) #2;
    reg_wr_in = 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e, string nm);
    @(posedge clk_in) #2;
    reg_addr_in = a;
    reg_rd_in = 1'b1;
    @(posedge clk_in) #2;
    reg_rd_in = 1'b0;
    chk(nm, e, reg_rdata_out);
  endtask
  task automatic frm(logic [15:0] t, logic [15:0] ln, logic [3:0] f, logic e);
    @(posedge clk_in) #2;
    frame_type_len_in = t;
    frame_len_in = ln;
    {frame_flow_ctl_in, frame_err_in, frame_vlan_cross_in, frame_known_ucast_in} = f;
    frame_valid_in = 1'b1;
    @(posedge clk_in) #2;
    frame_valid_in = 1'b0;
    chk("frame_done", 1, frame_done_out);
    chk("frame_keep", e, frame_keep_out);
  endtask
  task automatic gap(output int n);
    n = 0;
    do begin
      @(posedge clk_in) #2;
      n++;
    end while (age_tick_out !== 1'b1 && n < 400);
  endtask
  task automatic t_defaults;
    rd(`SGC_OFS_CTRL0, 8'h00, "ctrl0");
    rd(`SGC_OFS_CTRL1, 8'h31, "ctrl1");
    rd(`SGC_OFS_CTRL2, 8'h80, "ctrl2");
    rd(8'h05, 8'h00, "unmapped");
    chk("backoff", 1, backoff_aggr_out);
  endtask
  task automatic t_pause;
    wr(`SGC_OFS_CTRL1, 8'h60);
    rd(`SGC_OFS_CTRL1, 8'h60, "ctrl1");
    chk("tx_pause", 0, tx_pause_en_out);
    chk("rx_pause", 1, rx_pause_en_out);
    wr(`SGC_OFS_CTRL1, 8'h10);
    rd(`SGC_OFS_CTRL1, 8'h10, "ctrl1");
    chk("tx_pause", 1, tx_pause_en_out);
    chk("rx_pause", 0, rx_pause_en_out);
    an_tx_pause_in = 1'b0;
    repeat (2) @(posedge clk_in);
    #2 chk("tx_pause", 0, tx_pause_en_out);
  endtask
  task automatic t_frames;
    wr(`SGC_OFS_CTRL0, 8'h02);
    frm(16'h8808, 16'h0, 4'h0, 1'b0);
    frame_dest_in = `SGC_PAUSE_DEST;
    frm(16'h0800, 16'h0, 4'h0, 1'b0);
    frame_dest_in = 48'h0;
    frm(16'h0800, 16'h0, 4'h8, 1'b1);
    wr(`SGC_OFS_CTRL0, 8'h00);
    frm(16'h8808, 16'h0, 4'h0, 1'b1);
    frm(16'h0800, 16'h0, 4'h8, 1'b0);
    wr(`SGC_OFS_CTRL1, 8'h08);
    frm(16'd100, 16'd99, 4'h0, 1'b0);
    frm(16'd100, 16'd100, 4'h0, 1'b1);
    frm(16'd1500, 16'd0, 4'h0, 1'b1);
    frm(16'd1499, 16'd0, 4'h0, 1'b0);
    frm(16'h0800, 16'h0, 4'h4, 1'b0);
    frm(16'h0800, 16'h0, 4'h3, 1'b0);
    wr(`SGC_OFS_CTRL2, 8'h00);
    frm(16'h0800, 16'h0, 4'h3, 1'b1);
    frm(16'h0800, 16'h0, 4'h2, 1'b0);
    wr(`SGC_OFS_CTRL1, 8'h80);
    frm(16'd100, 16'd99, 4'hc, 1'b1);
    chk("pass_all", 1, pass_all_out);
  endtask
  task automatic t_age;
    int n;
    wr(`SGC_OFS_CTRL1, 8'h06);
    gap(n);
    gap(n);
    chk("fast_gap", 1, n >= 20 && n <= 22);
    wr(`SGC_OFS_CTRL1, 8'h04);
    gap(n);
    gap(n);
    chk("norm_gap", 1, n >= 200 && n <= 202);
    wr(`SGC_OFS_CTRL0, 8'h01);
    gap(n);
    link_up_in = 5'h17;
    @(posedge clk_in) #2;
    chk("flush", 1, flush_all_out);
    gap(n);
    chk("link_fast", 1, n <= 25);
    gap(n);
    chk("link_norm", 1, n >= 200 && n <= 202);
  endtask
  task automatic t_reset;
    int n;
    // Low enable must swallow a write
    ce_in = 1'b0;
    wr(`SGC_OFS_CTRL2, 8'h80);
    ce_in = 1'b1;
    rd(`SGC_OFS_CTRL2, 8'h00, "ctrl2_frozen");
    // Pause strap low, backoff high, aging high
    {pause_strap_pin_in, backoff_strap_pin_in, aging_strap_pin_in} = 3'b011;
    an_tx_pause_in = 1'b1;
    rst_n_in = 1'b0;
    repeat (2) @(posedge clk_in);
    #2 chk("rst_rx_pause", 0, rx_pause_en_out);
    rst_n_in = 1'b1;
    repeat (4) @(posedge clk_in);
    rd(`SGC_OFS_CTRL1, 8'h05, "ctrl1_straps");
    chk("tx_pause", 1, tx_pause_en_out);
    chk("rx_pause", 1, rx_pause_en_out);
    // Link change age is off, so unplug flushes but keeps the normal period
    link_up_in = 5'h07;
    @(posedge clk_in) #2;
    chk("flush", 1, flush_all_out);
    gap(n);
    chk("no_fast", 1, n > 100);
  endtask
  task automatic end_sim;
    if (n_fail == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    forever #12.5 clk_in = ~clk_in;
  end
  // Whole run needs about 1000 cycles
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      end_sim;
    end
  end
  initial begin
    repeat (12) @(posedge clk_in);
    #2 rst_n_in = 1'b1;
    repeat (4) @(posedge clk_in);
    t_defaults;
    t_pause;
    t_frames;
    t_age;
    t_reset;
    end_sim;
  end
endmodule // sgc_top_bench
